// *** rmt_cfg.svh ***
// Register offsets, reset values and timing counts for the rest-mode timing bank
`ifndef RMT_CFG_SVH
`define RMT_CFG_SVH
`define RMT_ADDR_CAPTURE 7'h12
`define RMT_ADDR_FWLOAD 7'h13
`define RMT_ADDR_RUN_DLY 7'h14
`define RMT_ADDR_R1_PER 7'h15
`define RMT_ADDR_R1_DLY 7'h16
`define RMT_ADDR_R2_PER 7'h17
`define RMT_ADDR_R2_DLY 7'h18
`define RMT_ADDR_R3_PER 7'h19
`define RMT_ADDR_FP_MAX_LO 7'h1a
`define RMT_ADDR_CONFIG2 7'h10
`define RMT_RST_CAPTURE 8'h00
`define RMT_RST_FWLOAD 8'h00
`define RMT_RST_RUN_DLY 8'h32
`define RMT_RST_R1_PER 8'h01
`define RMT_RST_R1_DLY 8'h1f
`define RMT_RST_R2_PER 8'h09
`define RMT_RST_R2_DLY 8'hbc
`define RMT_RST_R3_PER 8'h31
`define RMT_RST_FP_MAX_LO 8'hc0
`define RMT_RST_CONFIG2 8'h00
`define RMT_CFG2_FREST_HI 7
`define RMT_CFG2_FREST_LO 6
`define RMT_CFG2_REST_EN 5
`define RMT_CRC_START 8'h15
`define RMT_CLK_HZ 50000000
`define RMT_TICK_MS 10
`define RMT_TICK_CYCLES ((`RMT_CLK_HZ / 1000) * `RMT_TICK_MS)
`define RMT_R1_MULT 16
`define RMT_R2_MULT 32
`define RMT_CRC_TIME_MS 10
`define RMT_CRC_CYCLES ((`RMT_CLK_HZ / 1000) * `RMT_CRC_TIME_MS)
`endif

// *** rmt_pkg.sv ***
// Types shared by the rest-mode timing bank
package rmt_pkg;
	typedef enum logic [1:0] {
		RMT_RUN = 2'b00,
		RMT_REST1 = 2'b01,
		RMT_REST2 = 2'b10,
		RMT_REST3 = 2'b11
	} rmt_mode_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} rmt_req_t;
	typedef struct packed {
		logic [1:0] force_rest;
		logic rest_en;
	} rmt_cfg_t;
endpackage

// *** rmt_tick.sv ***
// Free-running divider giving one pulse per period
`timescale 1ns/100ps
module rmt_tick #(
	parameter int PERIOD = 500000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Tick out
	output logic tick
);
	if (PERIOD < 2) begin
		$error("PERIOD too small");
	end
	logic [31:0] cnt_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 32'h0;
			tick <= 1'b0;
		end else if (cnt_reg == 32'(PERIOD - 1)) begin
			cnt_reg <= 32'h0;
			tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h1;
			tick <= 1'b0;
		end
	end
endmodule

// *** rmt_frame_timer.sv ***
// Counts ticks and pulses when a programmed count is reached
`timescale 1ns/100ps
module rmt_frame_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic restart,
	input wire logic tick,
	input wire logic [W-1:0] limit,
	// Result
	output logic done
);
	if (W < 1) begin
		$error("W too small");
	end
	logic [W-1:0] cnt_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			done <= 1'b0;
		end else if (restart) begin
			cnt_reg <= '0;
			done <= 1'b0;
		end else if (tick) begin
			if (cnt_reg + W'(1) >= limit) begin
				cnt_reg <= '0;
				done <= 1'b1;
			end else begin
				cnt_reg <= cnt_reg + W'(1);
				done <= 1'b0;
			end
		end else begin
			done <= 1'b0;
		end
	end
endmodule

// *** rmt_regs.sv ***
// Rest-mode timing register bank with frame capture and firmware load triggers
//
// Overview of operation
// - Capture write grabs next frame into RAM
// - Capture write clobbers firmware, stops navigation
// - Firmware trigger write-only, reset zero, starts
// - CRC test halts navigation; controller stays quiet
// - Run to Rest1 after delay byte times 10ms
// - Run delay timed from system clock
// - Rest1 frame period (byte+1) times 10ms
// - Rest1 to Rest2 after byte*16 Rest1 periods
// - Rest2 frame period (byte+1) times 10ms
// - Rest2 to Rest3 after byte*32 Rest2 periods
// - Rest3 frame period (byte+1) times 10ms
// - Rest timing from 100 Hz hibernate tick
// - Rest modes only while rest enable set
// - Force-rest field holds chosen rest mode
// - Step down without motion, motion returns Run
`timescale 1ns/100ps
`include "rmt_cfg.svh"
module rmt_regs #(
	parameter int TICK_CYCLES = `RMT_TICK_CYCLES,
	parameter int HIB_CYCLES = `RMT_TICK_CYCLES,
	parameter int CRC_CYCLES = `RMT_CRC_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register port from serial interface
	input wire rmt_pkg::rmt_req_t req,
	output logic [7:0] rdata,
	// Configuration from second configuration register
	input wire rmt_pkg::rmt_cfg_t cfg,
	// Core status and requests
	input wire logic motion,
	input wire logic frame_done,
	output logic [1:0] mode,
	output logic frame_req,
	output logic nav_en,
	output logic capture_arm,
	output logic fw_load_start,
	output logic crc_start,
	output logic crc_busy,
	output logic [7:0] frame_period_ceiling_bits
);
	if (TICK_CYCLES < 2 || HIB_CYCLES < 2 || CRC_CYCLES < 2) begin
		$error("Counts too small");
	end

	logic [7:0] run_dly_reg, r1_per_reg, r1_dly_reg, r2_per_reg, r2_dly_reg, r3_per_reg;
	logic [7:0] capture_trigger_bits;
	logic [7:0] fp_max_lo_reg;
	rmt_pkg::rmt_mode_t mode_reg, mode_next;
	logic wr_capture, wr_fwload;
	logic sys_tick, hib_tick;
	logic run_done, rest_frame, rest_dly_done;
	logic mode_chg, restart_dly;
	logic [8:0] per_limit;
	logic [12:0] dly_limit;
	logic [31:0] crc_cnt_reg;

	assign wr_capture = req.wr && req.addr == `RMT_ADDR_CAPTURE;
	assign wr_fwload = req.wr && req.addr == `RMT_ADDR_FWLOAD;

	// Writable registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_trigger_bits <= `RMT_RST_CAPTURE;
			run_dly_reg <= `RMT_RST_RUN_DLY;
			r1_per_reg <= `RMT_RST_R1_PER;
			r1_dly_reg <= `RMT_RST_R1_DLY;
			r2_per_reg <= `RMT_RST_R2_PER;
			r2_dly_reg <= `RMT_RST_R2_DLY;
			r3_per_reg <= `RMT_RST_R3_PER;
			fp_max_lo_reg <= `RMT_RST_FP_MAX_LO;
		end else if (req.wr) begin
			case (req.addr)
				`RMT_ADDR_CAPTURE: capture_trigger_bits <= req.wdata;
				`RMT_ADDR_RUN_DLY: run_dly_reg <= req.wdata;
				`RMT_ADDR_R1_PER: r1_per_reg <= req.wdata;
				`RMT_ADDR_R1_DLY: r1_dly_reg <= req.wdata;
				`RMT_ADDR_R2_PER: r2_per_reg <= req.wdata;
				`RMT_ADDR_R2_DLY: r2_dly_reg <= req.wdata;
				`RMT_ADDR_R3_PER: r3_per_reg <= req.wdata;
				`RMT_ADDR_FP_MAX_LO: fp_max_lo_reg <= req.wdata;
				default: ;
			endcase
		end
	end

	// Read data; firmware trigger is write-only and reads zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			case (req.addr)
				`RMT_ADDR_CAPTURE: rdata <= capture_trigger_bits;
				`RMT_ADDR_RUN_DLY: rdata <= run_dly_reg;
				`RMT_ADDR_R1_PER: rdata <= r1_per_reg;
				`RMT_ADDR_R1_DLY: rdata <= r1_dly_reg;
				`RMT_ADDR_R2_PER: rdata <= r2_per_reg;
				`RMT_ADDR_R2_DLY: rdata <= r2_dly_reg;
				`RMT_ADDR_R3_PER: rdata <= r3_per_reg;
				`RMT_ADDR_FP_MAX_LO: rdata <= fp_max_lo_reg;
				default: rdata <= 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_period_ceiling_bits <= `RMT_RST_FP_MAX_LO;
		end else begin
			frame_period_ceiling_bits <= fp_max_lo_reg;
		end
	end

	// Capture arms a frame grab; firmware stays clobbered until reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_arm <= 1'b0;
		end else if (wr_capture) begin
			capture_arm <= 1'b1;
		end else if (frame_done) begin
			capture_arm <= 1'b0;
		end
	end

	// Firmware load and CRC test launch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fw_load_start <= 1'b0;
			crc_start <= 1'b0;
		end else begin
			fw_load_start <= wr_fwload && req.wdata != `RMT_CRC_START;
			crc_start <= wr_fwload && req.wdata == `RMT_CRC_START;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			crc_busy <= 1'b0;
			crc_cnt_reg <= 32'h0;
		end else if (wr_fwload && req.wdata == `RMT_CRC_START) begin
			crc_busy <= 1'b1;
			crc_cnt_reg <= 32'h0;
		end else if (crc_busy) begin
			if (crc_cnt_reg == 32'(CRC_CYCLES - 1)) begin
				crc_busy <= 1'b0;
			end
			crc_cnt_reg <= crc_cnt_reg + 32'h1;
		end
	end

	// Navigation stops on capture and while CRC runs
	logic fw_lost_reg;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fw_lost_reg <= 1'b0;
			nav_en <= 1'b1;
		end else begin
			if (wr_capture) begin
				fw_lost_reg <= 1'b1;
			end
			nav_en <= !(fw_lost_reg || wr_capture || crc_busy ||
				(wr_fwload && req.wdata == `RMT_CRC_START));
		end
	end

	// Timebases
	rmt_tick #(.PERIOD(TICK_CYCLES)) u_sys_tick (
		.clk(clk),
		.arst_n(arst_n),
		.tick(sys_tick)
	);
	rmt_tick #(.PERIOD(HIB_CYCLES)) u_hib_tick (
		.clk(clk),
		.arst_n(arst_n),
		.tick(hib_tick)
	);

	// Frame period and downshift delay selection
	always_comb begin
		case (mode_reg)
			rmt_pkg::RMT_REST1: begin
				per_limit = {1'b0, r1_per_reg} + 9'h1;
				dly_limit = {r1_dly_reg, 5'h0} >> 1;
			end
			rmt_pkg::RMT_REST2: begin
				per_limit = {1'b0, r2_per_reg} + 9'h1;
				dly_limit = {r2_dly_reg, 5'h0};
			end
			rmt_pkg::RMT_REST3: begin
				per_limit = {1'b0, r3_per_reg} + 9'h1;
				dly_limit = 13'h0;
			end
			default: begin
				per_limit = 9'h1;
				dly_limit = 13'h0;
			end
		endcase
	end

	assign mode_chg = mode_next != mode_reg;
	assign restart_dly = motion || mode_chg;

	rmt_frame_timer #(.W(9)) u_run_dly (
		.clk(clk),
		.arst_n(arst_n),
		.restart(restart_dly || mode_reg != rmt_pkg::RMT_RUN),
		.tick(sys_tick),
		.limit({1'b0, run_dly_reg}),
		.done(run_done)
	);
	rmt_frame_timer #(.W(9)) u_rest_frame (
		.clk(clk),
		.arst_n(arst_n),
		.restart(mode_chg || mode_reg == rmt_pkg::RMT_RUN),
		.tick(hib_tick),
		.limit(per_limit),
		.done(rest_frame)
	);
	rmt_frame_timer #(.W(13)) u_rest_dly (
		.clk(clk),
		.arst_n(arst_n),
		.restart(restart_dly || mode_reg == rmt_pkg::RMT_RUN),
		.tick(rest_frame),
		.limit(dly_limit),
		.done(rest_dly_done)
	);

	// Mode selection
	always_comb begin
		mode_next = mode_reg;
		if (!cfg.rest_en) begin
			mode_next = rmt_pkg::RMT_RUN;
		end else if (cfg.force_rest != 2'b00) begin
			mode_next = rmt_pkg::rmt_mode_t'(cfg.force_rest);
		end else if (motion) begin
			mode_next = rmt_pkg::RMT_RUN;
		end else begin
			case (mode_reg)
				rmt_pkg::RMT_RUN: if (run_done && run_dly_reg != 8'h00) mode_next = rmt_pkg::RMT_REST1;
				rmt_pkg::RMT_REST1: if (rest_dly_done && r1_dly_reg != 8'h00) mode_next = rmt_pkg::RMT_REST2;
				rmt_pkg::RMT_REST2: if (rest_dly_done && r2_dly_reg != 8'h00) mode_next = rmt_pkg::RMT_REST3;
				rmt_pkg::RMT_REST3: mode_next = rmt_pkg::RMT_REST3;
				default: mode_next = rmt_pkg::RMT_RUN;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_reg <= rmt_pkg::RMT_RUN;
			mode <= 2'b00;
			frame_req <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			mode <= mode_next;
			frame_req <= rest_frame && mode_reg != rmt_pkg::RMT_RUN;
		end
	end

	AST_CRC_NAV: assert property (@(posedge clk) disable iff (!arst_n)
		crc_busy |-> !nav_en) else $error("Navigation during CRC test");
	AST_CAPTURE_STOP: assert property (@(posedge clk) disable iff (!arst_n)
		wr_capture |=> ##1 !nav_en [*4]) else $error("Capture did not stop navigation");
	AST_CAPTURE_ARM: assert property (@(posedge clk) disable iff (!arst_n)
		wr_capture |=> capture_arm) else $error("Capture not armed");
	AST_CAPTURE_CLR: assert property (@(posedge clk) disable iff (!arst_n)
		(frame_done && !wr_capture) |=> !capture_arm) else $error("Capture not cleared");
	AST_NAV_LOST: assert property (@(posedge clk) disable iff (!arst_n)
		fw_lost_reg |-> !nav_en) else $error("Navigation with firmware lost");
	AST_CRC_START: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_fwload && req.wdata == `RMT_CRC_START) |=> crc_start && !fw_load_start && crc_busy)
		else $error("CRC test not started");
	AST_FW_START: assert property (@(posedge clk) disable iff (!arst_n)
		(wr_fwload && req.wdata != `RMT_CRC_START) |=> fw_load_start && !crc_start)
		else $error("Download not started");
	AST_WO_READ: assert property (@(posedge clk) disable iff (!arst_n)
		(req.rd && req.addr == `RMT_ADDR_FWLOAD) |=> rdata == 8'h00)
		else $error("Write-only register read back");
	AST_CRC_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		(crc_busy && crc_cnt_reg < 32'(CRC_CYCLES - 1)) |=> crc_busy)
		else $error("CRC test ended early");
	AST_CRC_END: assert property (@(posedge clk) disable iff (!arst_n)
		($fell(crc_busy) && !fw_lost_reg && !wr_capture && !wr_fwload) |=> nav_en)
		else $error("Navigation not resumed after CRC test");
	AST_REST_OFF: assert property (@(posedge clk) disable iff (!arst_n)
		!cfg.rest_en |=> mode_reg == rmt_pkg::RMT_RUN) else $error("Rest mode while disabled");
	AST_FORCE: assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.rest_en && cfg.force_rest != 2'b00) |=> mode_reg == $past(cfg.force_rest))
		else $error("Forced rest mode not held");
	AST_MOTION_RUN: assert property (@(posedge clk) disable iff (!arst_n)
		(cfg.rest_en && cfg.force_rest == 2'b00 && motion) |=> mode_reg == rmt_pkg::RMT_RUN)
		else $error("Motion did not return to run");
	AST_RUN_DOWN: assert property (@(posedge clk) disable iff (!arst_n)
		(mode_reg == rmt_pkg::RMT_RUN && $past(mode_reg) != rmt_pkg::RMT_RUN) |-> ##1
		(mode_reg == rmt_pkg::RMT_RUN || $past(cfg.force_rest) != 2'b00))
		else $error("Run left too early");
	AST_STEP: assert property (@(posedge clk) disable iff (!arst_n)
		(mode_reg == rmt_pkg::RMT_REST1 && $past(mode_reg) == rmt_pkg::RMT_RUN && !cfg.force_rest[1])
		|-> $past(run_done) || $past(cfg.force_rest) == 2'b01) else $error("Bad step to rest one");
	AST_STEP_TWO: assert property (@(posedge clk) disable iff (!arst_n)
		(mode_reg == rmt_pkg::RMT_REST2 && $past(mode_reg) == rmt_pkg::RMT_REST1 &&
		$past(cfg.force_rest) == 2'b00) |-> $past(rest_dly_done))
		else $error("Bad step to rest two");
	AST_STEP_THREE: assert property (@(posedge clk) disable iff (!arst_n)
		(mode_reg == rmt_pkg::RMT_REST3 && $past(mode_reg) == rmt_pkg::RMT_REST2 &&
		$past(cfg.force_rest) == 2'b00) |-> $past(rest_dly_done))
		else $error("Bad step to rest three");
	AST_FRAME: assert property (@(posedge clk) disable iff (!arst_n)
		frame_req |-> $past(mode_reg) != rmt_pkg::RMT_RUN && $past(hib_tick, 2))
		else $error("Rest frame in run");
endmodule

// *** rmt_host_model.sv ***
// Controller model driving the register port of the rest-mode timing bank
`timescale 1ns/100ps
module rmt_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output rmt_pkg::rmt_req_t req,
	input wire logic [7:0] rdata,
	input wire logic crc_busy
);
	initial req = '0;
	// Holds back all traffic while the CRC test runs
	task automatic quiet();
		int i;
		for (i = 0; i < 1000 && crc_busy !== 1'b0; i++) @(negedge clk);
	endtask
	// Released address and data lines show the inverse of the last value
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		quiet();
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		quiet();
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: req.wdata};
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~req.wdata};
		@(negedge clk);
		d = rdata;
	endtask
endmodule

// *** tb_rest_mode_timing_regs.sv ***
// Self-checking bench for the rest-mode timing bank
`timescale 1ns/100ps
`include "rmt_cfg.svh"
module tb_rest_mode_timing_regs;
	typedef struct {logic [6:0] a; logic [7:0] w; logic [7:0] r0; logic [7:0] r1;} rmt_row_t;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic motion = 1'b0;
	logic frame_done = 1'b0;
	rmt_pkg::rmt_req_t req;
	rmt_pkg::rmt_cfg_t cfg = '0;
	logic [7:0] rdata, ceiling_bits, v;
	logic [1:0] mode;
	logic frame_req, nav_en, capture_arm, fw_load_start, crc_start, crc_busy;
	int n_errors = 0;
	int n_checks = 0;
	int n, p, f;
	int pe[4] = '{0, 8, 12, 16};
	rmt_row_t rows[9] = '{
		'{7'h14, 8'h03, `RMT_RST_RUN_DLY, 8'h03}, '{7'h15, 8'h01, `RMT_RST_R1_PER, 8'h01},
		'{7'h16, 8'h01, `RMT_RST_R1_DLY, 8'h01}, '{7'h17, 8'h02, `RMT_RST_R2_PER, 8'h02},
		'{7'h18, 8'h01, `RMT_RST_R2_DLY, 8'h01}, '{7'h19, 8'h03, `RMT_RST_R3_PER, 8'h03},
		'{7'h1a, 8'h5a, `RMT_RST_FP_MAX_LO, 8'h5a}, '{7'h13, 8'h00, 8'h00, 8'h00},
		'{7'h7f, 8'h77, 8'h00, 8'h00}};
	always #10 clk = ~clk;
	rmt_regs #(.TICK_CYCLES(4), .HIB_CYCLES(4), .CRC_CYCLES(8)) DUT (.clk(clk), .arst_n(arst_n),
		.req(req), .rdata(rdata), .cfg(cfg), .motion(motion), .frame_done(frame_done),
		.mode(mode), .frame_req(frame_req), .nav_en(nav_en), .capture_arm(capture_arm),
		.fw_load_start(fw_load_start), .crc_start(crc_start), .crc_busy(crc_busy),
		.frame_period_ceiling_bits(ceiling_bits));
	rmt_host_model u_host (.clk(clk), .req(req), .rdata(rdata), .crc_busy(crc_busy));
	task automatic results();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rng(input int x, input int lo, input int hi);
		chk({7'h00, x >= lo && x <= hi}, 8'h01);
	endtask
	task automatic wait_mode(input logic [1:0] m, input int lim, output int c);
		c = 0;
		while (mode !== m && c < lim) begin
			@(negedge clk);
			c++;
		end
		if (mode !== m) begin
			n_errors++;
			$display("[ERR] %0t mode wait ran out", $time);
			results();
		end
	endtask
	task automatic per(output int q);
		int i;
		q = 1;
		for (i = 0; i < 300 && frame_req !== 1'b1; i++) @(negedge clk);
		@(negedge clk);
		while (frame_req !== 1'b1 && q < 300) begin
			@(negedge clk);
			q++;
		end
	endtask
	initial begin
		#2000000;
		n_errors++;
		results();
	end
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk({6'h00, mode}, 8'h00);
		chk({7'h00, nav_en}, 8'h01);
		chk(ceiling_bits, `RMT_RST_FP_MAX_LO);
		foreach (rows[i]) begin
			u_host.rd(rows[i].a, v);
			chk(v, rows[i].r0);
			u_host.wr(rows[i].a, rows[i].w);
			if (rows[i].a == 7'h13) begin
				@(negedge clk);
				chk({7'h00, fw_load_start}, 8'h01);
			end
			u_host.rd(rows[i].a, v);
			chk(v, rows[i].r1);
		end
		chk(ceiling_bits, 8'h5a);
		// Second configuration register read before the CRC test; it lies outside this bank and reads zero
		u_host.rd(`RMT_ADDR_CONFIG2, v);
		chk(v, 8'h00);
		// Download done above, so a CRC test is now meaningful
		u_host.wr(7'h13, `RMT_CRC_START);
		@(negedge clk);
		chk({crc_start, crc_busy, nav_en}, 8'h06);
		n = 0;
		while (crc_busy === 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk(8'(n), 8'd8);
		@(negedge clk);
		chk({7'h00, nav_en}, 8'h01);
		// Rest disabled keeps Run
		repeat (40) @(negedge clk);
		chk({6'h00, mode}, 8'h00);
		@(posedge clk);
		cfg.rest_en <= 1'b1;
		repeat (5) begin
			@(posedge clk);
			motion <= 1'b1;
			repeat (7) @(posedge clk);
			motion <= 1'b0;
		end
		chk({6'h00, mode}, 8'h00);
		@(posedge clk);
		motion <= 1'b0;
		wait_mode(rmt_pkg::RMT_REST1, 100, n);
		rng(n, 8, 16);
		wait_mode(rmt_pkg::RMT_REST2, 400, n);
		rng(n, 120, 140);
		wait_mode(rmt_pkg::RMT_REST3, 600, n);
		rng(n, 372, 400);
		per(p);
		chk(8'(p), 8'd16);
		@(posedge clk);
		motion <= 1'b1;
		wait_mode(rmt_pkg::RMT_RUN, 10, n);
		for (f = 1; f < 4; f++) begin
			@(posedge clk);
			cfg.force_rest <= f[1:0];
			wait_mode(f[1:0], 20, n);
			per(p);
			chk(8'(p), 8'(pe[f]));
			repeat (20) @(negedge clk);
			chk({6'h00, mode}, 8'(f));
		end
		@(posedge clk);
		cfg.force_rest <= 2'b00;
		wait_mode(rmt_pkg::RMT_RUN, 20, n);
		u_host.wr(7'h12, 8'h01);
		@(negedge clk);
		chk({6'h00, capture_arm, nav_en}, 8'h02);
		u_host.rd(7'h12, v);
		chk(v, 8'h01);
		@(posedge clk);
		frame_done <= 1'b1;
		@(posedge clk);
		frame_done <= 1'b0;
		repeat (10) @(negedge clk);
		chk({6'h00, capture_arm, nav_en}, 8'h00);
		// Controller resets the device to restore navigation
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		chk({7'h00, nav_en}, 8'h01);
		u_host.rd(7'h12, v);
		chk(v, `RMT_RST_CAPTURE);
		results();
	end
endmodule
